// [csbp_pkg.sv]
// Purpose: shared constants and types of the status and bit processor
// Assumes: 32-bit AHB-Lite register bus, one aligned word per register
// Notes: bit space below 80h sits in internal RAM bytes 20h-2Fh
`default_nettype none
package csbp_pkg;
    // ----------------------------------------
    // register byte offsets
    // ----------------------------------------
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_IPTR = 8'h04;
    localparam logic [7:0] ADDR_DPTR = 8'h08;
    localparam logic [7:0] ADDR_PSW = 8'h0c;
    localparam logic [7:0] ADDR_ACC = 8'h10;
    localparam logic [7:0] ADDR_RESULT = 8'h14;
    localparam logic [7:0] ADDR_PORT = 8'h18;
    localparam logic [7:0] ADDR_BREG = 8'h1c;

    // ----------------------------------------
    // status word bit positions
    // ----------------------------------------
    localparam int PSW_CARRY = 7;
    localparam int PSW_HALF = 6;
    localparam int PSW_FLAG0 = 5;
    localparam int PSW_BANK_HIGH = 4;
    localparam int PSW_BANK_LOW = 3;
    localparam int PSW_RANGE = 2;
    localparam int PSW_FLAG1 = 1;
    localparam int PSW_PARITY = 0;
    localparam logic [7:0] PSW_STORED_MASK = 8'hfe;

    // ----------------------------------------
    // reset values
    // ----------------------------------------
    localparam logic [15:0] IPTR_RESET = 16'h0000;
    localparam logic [15:0] DPTR_RESET = 16'h0000;
    localparam logic [7:0] PSW_RESET = 8'h00;
    localparam logic [7:0] ACC_RESET = 8'h00;
    localparam logic [7:0] BREG_RESET = 8'h00;
    localparam logic [7:0] PORT_RESET = 8'hff;

    // ----------------------------------------
    // internal RAM and bit space
    // ----------------------------------------
    localparam int IRAM_DEPTH = 48;
    localparam logic [7:0] BIT_RAM_BASE = 8'h20;
    localparam logic [7:0] SFR_PORT = 8'h90;
    localparam logic [7:0] SFR_PSW = 8'hd0;
    localparam logic [7:0] SFR_ACC = 8'he0;
    localparam logic [7:0] SFR_BREG = 8'hf0;
    localparam int RESULT_BIT_POS = 8;
    localparam int RESULT_TAKEN_POS = 9;

    // ----------------------------------------
    // command codes, in order from 0
    // ----------------------------------------
    typedef enum logic [4:0] {
        OP_NOP, OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_CARRY, OP_ROT_LEFT, OP_ROT_RIGHT,
        OP_CLEAR_SIGNED_RANGE, OP_BIT_TEST, OP_MOVE_TO_CARRY, OP_MOVE_FROM_CARRY,
        OP_BIT_SET, OP_BIT_CLEAR, OP_BIT_INVERT, OP_BIT_AND, OP_BIT_AND_NOT, OP_BIT_OR,
        OP_BIT_OR_NOT, OP_JUMP_IF_CARRY, OP_JUMP_IF_NO_CARRY, OP_JUMP_IF_BIT_SET,
        OP_JUMP_IF_BIT_ZERO, OP_JUMP_SET_AND_CLEAR, OP_WRITE_REG, OP_READ_REG
    } csbp_op_e;

    typedef struct packed {
        logic [7:0] target;
        logic [7:0] operand;
        logic [7:0] addr;
        logic [7:0] op;
    } csbp_cmd_s;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] addr;
    } csbp_ahb_req_s;
endpackage
`default_nettype wire

// [csbp_alu.sv]
// Purpose: adder with carry, half-carry and signed-range outputs
// Assumes: subtraction is a + ~b + carry, so carry means no borrow
// Notes: half-carry is the carry out of the low nibble
`default_nettype none
module csbp_alu #(
    parameter int W = 8
) (
    // operands
    input wire logic [W-1:0] a_i,
    input wire logic [W-1:0] b_i,
    input wire logic cin_i,
    input wire logic sub_i,
    // results
    output logic [W-1:0] sum_o,
    output logic carry_o,
    output logic half_o,
    output logic range_o
);
    wire logic [W-1:0] b_eff = sub_i ? ~b_i : b_i;
    wire logic [W:0] full = {1'b0, a_i} + {1'b0, b_eff} + {{W{1'b0}}, cin_i};
    wire logic [4:0] low = {1'b0, a_i[3:0]} + {1'b0, b_eff[3:0]} + {4'h0, cin_i};

    assign sum_o = full[W-1:0];
    assign carry_o = full[W];
    assign half_o = low[4];
    // signs alike in, sign differs out
    assign range_o = (a_i[W-1] == b_eff[W-1]) && (full[W-1] != a_i[W-1]);
endmodule
`default_nettype wire

// [csbp_core.sv]
// Purpose: status word, pointers and single-bit processor behind AHB-Lite
// Assumes: one command per write to the command register, done in one cycle
// Notes: what this block does, in short:
`default_nettype none
module csbp_core
    import csbp_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // ahb-lite slave
    input wire logic hsel_i,
    input wire logic [7:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // core state
    input wire logic [7:0] port_pins_i,
    output logic [7:0] port_latch_o,
    output logic [15:0] iptr_o,
    output logic [15:0] dptr_o,
    output logic [7:0] psw_o
);
    // ----------------------------------------
    // state
    // ----------------------------------------
    logic [15:0] iptr;
    logic [15:0] dptr;
    logic [7:0] program_status_word;
    logic [7:0] acc;
    logic [7:0] breg;
    logic [7:0] port_latch;
    logic [9:0] result;
    logic [7:0] iram [IRAM_DEPTH];
    csbp_ahb_req_s data_pointer_high;
    logic [31:0] rdata;

    logic [15:0] next_iptr;
    logic [15:0] next_dptr;
    logic [7:0] next_psw;
    logic [7:0] next_acc;
    logic [7:0] next_breg;
    logic [7:0] next_port;
    logic [9:0] next_result;
    logic ram_we;
    logic [5:0] ram_addr;
    logic [7:0] ram_wdata;
    logic bit_we;
    logic bit_new;
    logic taken;

    // ----------------------------------------
    // bus decode
    // ----------------------------------------
    wire logic addr_take = hsel_i && hready_i && htrans_i[1];
    wire logic bus_wr = data_pointer_high.valid && data_pointer_high.write && hready_i;
    wire logic exec = bus_wr && (data_pointer_high.addr == ADDR_CMD);
    wire csbp_cmd_s cmd = csbp_cmd_s'(hwdata_i);
    wire csbp_op_e op = csbp_op_e'(cmd.op[4:0]);

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign hrdata_o = rdata;

    // ----------------------------------------
    // status word and bit addressing
    // ----------------------------------------
    wire logic parity = ~^acc;
    wire logic [7:0] psw_full = {program_status_word[7:1], parity};
    wire logic cy = program_status_word[PSW_CARRY];
    wire logic [5:0] reg_ptr = {1'b0, program_status_word[PSW_BANK_HIGH], program_status_word[PSW_BANK_LOW], cmd.addr[2:0]};
    wire logic in_sfr = cmd.addr[7];
    wire logic [7:0] bit_byte = in_sfr ? {cmd.addr[7:3], 3'h0} : BIT_RAM_BASE + {4'h0, cmd.addr[6:3]};
    wire logic [2:0] bit_idx = cmd.addr[2:0];
    wire logic [7:0] bit_mask = 8'h01 << bit_idx;
    wire logic [7:0] ram_byte = iram[bit_byte[5:0]];
    // carry reachable at its own bit address via the status word
    wire logic [7:0] sfr_byte = (bit_byte == SFR_PORT) ? port_pins_i :
                                (bit_byte == SFR_PSW) ? psw_full :
                                (bit_byte == SFR_ACC) ? acc :
                                (bit_byte == SFR_BREG) ? breg : 8'h00;
    wire logic [7:0] src_byte = in_sfr ? sfr_byte : ram_byte;
    wire logic bit_val = src_byte[bit_idx];
    // modify writes of the port start from the latch, not the pins
    wire logic [7:0] rmw_byte = (in_sfr && bit_byte == SFR_PORT) ? port_latch : src_byte;
    wire logic [7:0] rmw_new = bit_new ? (rmw_byte | bit_mask) : (rmw_byte & ~bit_mask);

    // ----------------------------------------
    // adder
    // ----------------------------------------
    wire logic is_sub = (op == OP_SUB) || (op == OP_SUB_CARRY);
    wire logic alu_cin = (op == OP_SUB) ? 1'b1 : ((op == OP_ADD) ? 1'b0 : cy);
    logic [7:0] alu_sum;
    logic alu_carry;
    logic alu_half;
    logic alu_range;

    csbp_alu #(.W(8)) u_alu (
        .a_i(acc),
        .b_i(cmd.operand),
        .cin_i(alu_cin),
        .sub_i(is_sub),
        .sum_o(alu_sum),
        .carry_o(alu_carry),
        .half_o(alu_half),
        .range_o(alu_range)
    );

    // ----------------------------------------
    // command execution
    // ----------------------------------------
    always_comb begin
        next_iptr = iptr;
        next_dptr = dptr;
        next_psw = program_status_word;
        next_acc = acc;
        next_breg = breg;
        next_port = port_latch;
        next_result = result;
        ram_we = 1'b0;
        ram_addr = 6'h00;
        ram_wdata = 8'h00;
        bit_we = 1'b0;
        bit_new = 1'b0;
        taken = 1'b0;
        if (bus_wr && data_pointer_high.addr == ADDR_IPTR) begin
            next_iptr = hwdata_i[15:0];
        end
        if (bus_wr && data_pointer_high.addr == ADDR_DPTR) begin
            next_dptr = hwdata_i[15:0];
        end
        if (bus_wr && data_pointer_high.addr == ADDR_PSW) begin
            next_psw = hwdata_i[7:0] & PSW_STORED_MASK;
        end
        if (bus_wr && data_pointer_high.addr == ADDR_ACC) begin
            next_acc = hwdata_i[7:0];
        end
        if (bus_wr && data_pointer_high.addr == ADDR_BREG) begin
            next_breg = hwdata_i[7:0];
        end
        if (bus_wr && data_pointer_high.addr == ADDR_PORT) begin
            next_port = hwdata_i[7:0];
        end
        if (exec) begin
            next_iptr = iptr + 16'h0001;
            case (op)
                OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_CARRY: begin
                    next_acc = alu_sum;
                    next_psw[PSW_CARRY] = alu_carry;
                    next_psw[PSW_HALF] = alu_half;
                    next_psw[PSW_RANGE] = alu_range;
                end
                OP_ROT_LEFT: begin
                    next_acc = {acc[6:0], cy};
                    next_psw[PSW_CARRY] = acc[7];
                end
                OP_ROT_RIGHT: begin
                    next_acc = {cy, acc[7:1]};
                    next_psw[PSW_CARRY] = acc[0];
                end
                OP_CLEAR_SIGNED_RANGE: next_psw[PSW_RANGE] = 1'b0;
                OP_BIT_TEST: next_psw[PSW_RANGE] = cmd.operand[6];
                OP_MOVE_TO_CARRY: next_psw[PSW_CARRY] = bit_val;
                OP_MOVE_FROM_CARRY: begin
                    bit_we = 1'b1;
                    bit_new = cy;
                end
                OP_BIT_SET: begin
                    bit_we = 1'b1;
                    bit_new = 1'b1;
                end
                OP_BIT_CLEAR: bit_we = 1'b1;
                OP_BIT_INVERT: begin
                    bit_we = 1'b1;
                    bit_new = ~bit_val;
                end
                OP_BIT_AND: next_psw[PSW_CARRY] = cy & bit_val;
                OP_BIT_AND_NOT: next_psw[PSW_CARRY] = cy & ~bit_val;
                OP_BIT_OR: next_psw[PSW_CARRY] = cy | bit_val;
                OP_BIT_OR_NOT: next_psw[PSW_CARRY] = cy | ~bit_val;
                OP_JUMP_IF_CARRY: taken = cy;
                OP_JUMP_IF_NO_CARRY: taken = ~cy;
                OP_JUMP_IF_BIT_SET: taken = bit_val;
                OP_JUMP_IF_BIT_ZERO: taken = ~bit_val;
                OP_JUMP_SET_AND_CLEAR: begin
                    taken = bit_val;
                    bit_we = bit_val;
                end
                OP_WRITE_REG: begin
                    ram_we = 1'b1;
                    ram_addr = reg_ptr;
                    ram_wdata = cmd.operand;
                end
                OP_READ_REG: next_result[7:0] = iram[reg_ptr];
                default: ;
            endcase
            if (taken) begin
                next_iptr = iptr + 16'h0001 + {{8{cmd.target[7]}}, cmd.target};
            end
            next_result[RESULT_BIT_POS] = bit_val;
            next_result[RESULT_TAKEN_POS] = taken;
            if (bit_we && !in_sfr) begin
                ram_we = 1'b1;
                ram_addr = bit_byte[5:0];
                ram_wdata = rmw_new;
            end
            if (bit_we && in_sfr && bit_byte == SFR_PSW) begin
                next_psw = rmw_new & PSW_STORED_MASK;
            end
            if (bit_we && in_sfr && bit_byte == SFR_ACC) begin
                next_acc = rmw_new;
            end
            if (bit_we && in_sfr && bit_byte == SFR_BREG) begin
                next_breg = rmw_new;
            end
            if (bit_we && in_sfr && bit_byte == SFR_PORT) begin
                next_port = rmw_new;
            end
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            iptr <= IPTR_RESET;
            dptr <= DPTR_RESET;
            program_status_word <= PSW_RESET;
            acc <= ACC_RESET;
            breg <= BREG_RESET;
            port_latch <= PORT_RESET;
            result <= 10'h000;
        end else begin
            iptr <= next_iptr;
            dptr <= next_dptr;
            program_status_word <= next_psw;
            acc <= next_acc;
            breg <= next_breg;
            port_latch <= next_port;
            result <= next_result;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < IRAM_DEPTH; i++) begin
                iram[i] <= 8'h00;
            end
        end else if (ram_we) begin
            iram[ram_addr] <= ram_wdata;
        end
    end

    // ----------------------------------------
    // bus phases and read data
    // ----------------------------------------
    wire logic [31:0] rd_mux = (haddr_i == ADDR_IPTR) ? {16'h0000, iptr} :
                               (haddr_i == ADDR_DPTR) ? {16'h0000, dptr} :
                               (haddr_i == ADDR_PSW) ? {24'h000000, psw_full} :
                               (haddr_i == ADDR_ACC) ? {24'h000000, acc} :
                               (haddr_i == ADDR_RESULT) ? {22'h000000, result} :
                               (haddr_i == ADDR_PORT) ? {24'h000000, port_latch} :
                               (haddr_i == ADDR_BREG) ? {24'h000000, breg} : 32'h00000000;

    always_ff @(posedge core_clk_i) begin
        if (!nrst_i) begin
            data_pointer_high <= '0;
            rdata <= 32'h00000000;
        end else if (hready_i) begin
            data_pointer_high <= '{valid: addr_take, write: hwrite_i, addr: haddr_i};
            rdata <= (addr_take && !hwrite_i) ? rd_mux : 32'h00000000;
        end
    end

    assign port_latch_o = port_latch;
    assign iptr_o = iptr;
    assign dptr_o = dptr;
    assign psw_o = psw_full;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    wire logic exec_alu = exec && (op == OP_ADD || op == OP_ADD_CARRY || op == OP_SUB || op == OP_SUB_CARRY);
    wire logic exec_wreg = exec && op == OP_WRITE_REG;
    wire logic exec_set_ram = exec && op == OP_BIT_SET && !in_sfr;
    wire logic exec_set_port = exec && op == OP_BIT_SET && in_sfr && bit_byte == SFR_PORT;
    wire logic [5:0] bit_ram_addr = bit_byte[5:0];
    wire logic op_bit6 = cmd.operand[6];
    wire logic [15:0] jump_pc = iptr + 16'h0001 + {{8{cmd.target[7]}}, cmd.target};

    sequence s_jsc_hit;
        exec && op == OP_JUMP_SET_AND_CLEAR && bit_val && !in_sfr;
    endsequence
    sequence s_jsc_done;
        result[RESULT_TAKEN_POS] && iptr == $past(jump_pc) && !iram[$past(bit_ram_addr)][$past(bit_idx)];
    endsequence

    property p_iptr_reset;
        @(posedge core_clk_i) !nrst_i |=> iptr == 16'h0000 && dptr == 16'h0000;
    endproperty
    a_iptr_reset: assert property (p_iptr_reset) else $error("pointer not zero after reset");

    property p_parity;
        @(posedge core_clk_i) disable iff (!nrst_i) exec_alu |=> psw_o[PSW_PARITY] == ~^$past(alu_sum);
    endproperty
    a_parity: assert property (p_parity) else $error("parity count not even");

    property p_alu_flags;
        @(posedge core_clk_i) disable iff (!nrst_i)
            exec_alu |=> program_status_word[PSW_CARRY] == $past(alu_carry) && program_status_word[PSW_HALF] == $past(alu_half)
                && program_status_word[PSW_RANGE] == $past(alu_range) && acc == $past(alu_sum);
    endproperty
    a_alu_flags: assert property (p_alu_flags) else $error("adder flags not captured");

    property p_bank_write;
        @(posedge core_clk_i) disable iff (!nrst_i) exec_wreg |=> iram[$past(reg_ptr)] == $past(cmd.operand);
    endproperty
    a_bank_write: assert property (p_bank_write) else $error("register bank write lost");

    property p_range_clear;
        @(posedge core_clk_i) disable iff (!nrst_i)
            exec && op == OP_CLEAR_SIGNED_RANGE |=> !program_status_word[PSW_RANGE] ##1 (!program_status_word[PSW_RANGE] || $past(bus_wr));
    endproperty
    a_range_clear: assert property (p_range_clear) else $error("signed range not cleared");

    property p_bit_test;
        @(posedge core_clk_i) disable iff (!nrst_i) exec && op == OP_BIT_TEST |=> program_status_word[PSW_RANGE] == $past(op_bit6);
    endproperty
    a_bit_test: assert property (p_bit_test) else $error("bit 6 not copied");

    property p_jump_no_carry;
        @(posedge core_clk_i) disable iff (!nrst_i)
            exec && op == OP_JUMP_IF_NO_CARRY |=> result[RESULT_TAKEN_POS] == !$past(cy);
    endproperty
    a_jump_no_carry: assert property (p_jump_no_carry) else $error("no-carry jump wrong");

    property p_jsc;
        @(posedge core_clk_i) disable iff (!nrst_i) s_jsc_hit |=> s_jsc_done;
    endproperty
    a_jsc: assert property (p_jsc) else $error("set-and-clear jump wrong");

    property p_ram_bit;
        @(posedge core_clk_i) disable iff (!nrst_i) exec_set_ram |=> iram[$past(bit_ram_addr)][$past(bit_idx)];
    endproperty
    a_ram_bit: assert property (p_ram_bit) else $error("ram bit not set");

    property p_port_bit;
        @(posedge core_clk_i) disable iff (!nrst_i) exec_set_port |=> port_latch_o[$past(bit_idx)];
    endproperty
    a_port_bit: assert property (p_port_bit) else $error("port line not set");
endmodule
`default_nettype wire

// [csbp_port_model.sv]
// Purpose: port lines outside the core
// Assumes: pulled-up lines, a load may pull any low
// Notes: a pin reads low if latch or load pulls low
`default_nettype none
module csbp_port_model (
    // from the core
    input wire logic [7:0] latch_i,
    // external load
    input wire logic [7:0] pull_low_i,
    // pin levels
    output logic [7:0] pins_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pins_o = latch_i & ~pull_low_i;
endmodule
`default_nettype wire

// [cpu_status_and_bit_processor_test.sv]
// Purpose: self-checking bench of the status and bit processor
// Assumes: zero-wait AHB-Lite slave, one command per write
// Notes: iptr is modelled from every command sent
`default_nettype none
module cpu_status_and_bit_processor_test
    import csbp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // ----
    // rows: psw, acc, op, operand, acc after, psw after
    // ----
    localparam logic [47:0] ALU_T [12] = '{48'h00_78_01_08_80_44, 48'h00_00_03_01_ff_01,
        48'h00_ff_01_01_00_c1, 48'h00_81_05_00_02_80, 48'h80_02_06_00_81_01, 48'h80_10_04_05_0b_80,
        48'h04_00_07_00_00_01, 48'h00_00_08_40_00_05, 48'h04_00_08_bf_00_01, 48'h80_7f_02_00_80_44,
        48'h00_80_03_01_7f_84, 48'h00_5a_00_00_5a_01};
    localparam logic [23:0] BIT_T [20] = '{24'h0c_7f_01, 24'h0b_7f_01, 24'h09_7f_81, 24'h0d_7f_81,
        24'h0e_7f_01, 24'h11_7f_81, 24'h10_7f_81, 24'h0f_7f_81, 24'h0a_00_81, 24'h0c_d7_01, 24'h09_00_81,
        24'h0c_d7_01, 24'h09_d0_81, 24'h0b_d3_89, 24'h0c_d3_81, 24'h0c_90_81, 24'h0c_92_81, 24'h0b_92_81,
        24'h09_90_01, 24'h09_91_01};
    localparam logic [31:0] JMP_T [9] = '{32'h12_00_08_00, 32'h13_00_f0_01, 32'h14_00_04_01,
        32'h15_00_04_00, 32'h16_00_7f_01, 32'h16_00_7f_00, 32'h15_00_80_01, 32'h14_d0_02_01, 32'h14_7f_05_00};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] haddr = 8'h00;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] pull_low = 8'h00;
    logic hready;
    logic hresp;
    logic [31:0] hrdata;
    logic [7:0] pins, latch, program_status_word;
    logic [15:0] iptr, dptr, ip;
    logic [31:0] got;
    int fails = 0;
    int n_tests = 0;
    always #10 clk = ~clk;
    csbp_core csbp_core_i (.core_clk_i(clk), .nrst_i(nrst), .hsel_i(1'b1), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'b010), .hwdata_i(hwdata), .hready_i(hready),
        .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata), .port_pins_i(pins), .port_latch_o(latch),
        .iptr_o(iptr), .dptr_o(dptr), .psw_o(program_status_word));
    csbp_port_model csbp_port_model_i (.latch_i(latch), .pull_low_i(pull_low), .pins_o(pins));
    // ----
    // bus tasks
    // ----
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= w;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'b00;
        hwdata <= d;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        got = hrdata;
    endtask
    task automatic cmp(input logic [31:0] g, input logic [31:0] e, input string m);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, g, e);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
        xfer(1'b0, a, 32'h0);
        cmp(got, e, m);
        cmp({31'h0, hresp}, 32'h0, "okay response");
    endtask
    task automatic cmd(input logic [7:0] op, input logic [7:0] b, input logic [7:0] v, input logic [7:0] off,
                       input logic tk);
        xfer(1'b1, ADDR_CMD, {off, v, b, 3'b000, op[4:0]});
        ip = ip + 16'h0001 + (tk ? {{8{off[7]}}, off} : 16'h0000);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        #400000;
        fails++;
        $display("wrong value at %0t: watchdog expired", $time);
        end_of_test();
    end
    initial begin
        ip = 16'h0000;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(ADDR_IPTR, 32'h0, "iptr reset");
        rd(ADDR_DPTR, 32'h0, "dptr reset");
        rd(ADDR_PSW, 32'h01, "psw reset");
        rd(8'h20, 32'h0, "unmapped read");
        xfer(1'b1, ADDR_DPTR, 32'h5a5a_c3e1);
        rd(ADDR_DPTR, 32'h0000_c3e1, "dptr rw");
        cmp({16'h0, dptr}, 32'h0000_c3e1, "dptr pins");
        $display("test registers done");
        foreach (ALU_T[k]) begin
            xfer(1'b1, ADDR_PSW, {24'h0, ALU_T[k][47:40]});
            xfer(1'b1, ADDR_ACC, {24'h0, ALU_T[k][39:32]});
            cmd(ALU_T[k][31:24], 8'h00, ALU_T[k][23:16], 8'h00, 1'b0);
            rd(ADDR_ACC, {24'h0, ALU_T[k][15:8]}, "acc result");
            rd(ADDR_PSW, {24'h0, ALU_T[k][7:0]}, "psw flags");
            cmp({24'h0, program_status_word}, {24'h0, ALU_T[k][7:0]}, "psw pins");
        end
        cmp({16'h0, iptr}, {16'h0, ip}, "iptr count");
        $display("test arithmetic done");
        xfer(1'b1, ADDR_PSW, 32'h0);
        pull_low <= 8'h02;
        foreach (BIT_T[k]) begin
            cmd(BIT_T[k][23:16], BIT_T[k][15:8], 8'h00, 8'h00, 1'b0);
            rd(ADDR_PSW, {24'h0, BIT_T[k][7:0]}, "bit op carry");
        end
        cmp({24'h0, latch}, 32'h0000_00fe, "port latch");
        $display("test bit operations done");
        xfer(1'b1, ADDR_IPTR, 32'h0000_0100);
        ip = 16'h0100;
        foreach (JMP_T[k]) begin
            cmd(JMP_T[k][31:24], JMP_T[k][23:16], 8'h00, JMP_T[k][15:8], JMP_T[k][0]);
            xfer(1'b0, ADDR_RESULT, 32'h0);
            cmp({31'h0, got[RESULT_TAKEN_POS]}, {31'h0, JMP_T[k][0]}, "jump taken");
            cmp({16'h0, iptr}, {16'h0, ip}, "jump target");
        end
        $display("test jumps done");
        for (int b = 0; b < 4; b++) begin
            xfer(1'b1, ADDR_PSW, 32'(b * 8));
            for (int r = 0; r < 8; r++) cmd(8'd23, 8'(r), 8'(b * 16 + r + 1), 8'h00, 1'b0);
        end
        for (int b = 0; b < 4; b++) begin
            xfer(1'b1, ADDR_PSW, 32'(b * 8));
            for (int r = 0; r < 8; r++) begin
                cmd(8'd24, 8'(r), 8'h00, 8'h00, 1'b0);
                xfer(1'b0, ADDR_RESULT, 32'h0);
                cmp({24'h0, got[7:0]}, 32'(b * 16 + r + 1), "bank register");
                if (b == 3) cmp({24'h0, csbp_core_i.iram[24 + r]}, 32'(b * 16 + r + 1), "bank 3 place");
            end
        end
        cmp({16'h0, iptr}, {16'h0, ip}, "iptr after banks");
        $display("test register banks done");
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(ADDR_IPTR, 32'h0, "iptr after second reset");
        rd(ADDR_PSW, 32'h01, "psw after second reset");
        cmp({16'h0, dptr}, 32'h0, "dptr after second reset");
        cmp({24'h0, latch}, 32'h0000_00ff, "latch after second reset");
        $display("test second reset done");
        end_of_test();
    end
endmodule
`default_nettype wire
